// [hdl/hfc_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module hfc_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule : hfc_fifo

// [hdl/hfc_frontend_regs.sv]
// Serial front end, configuration registers and fault status word
`timescale 1ns/10ps
module hfc_frontend_regs #(
    parameter int unsigned TIMEOUT_CYC = hfc_pkg::NODATA_TIMEOUT_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    input  wire logic        sample_needed,
    input  wire logic        sample_strobe,
    input  wire logic [1:0]  controller_state,
    input  wire logic        high_voltage_sense_pin,
    input  wire logic        input_current_sense_pin,
    input  wire logic        short_detect,
    output logic [15:0]      synth_cmd_data,
    output logic             synth_cmd_valid,
    input  wire logic        synth_cmd_ready,
    output logic             synth_cmd_space,
    output logic [2:0]       playback_rate,
    output logic [1:0]       waveform_mode,
    output logic             output_enable,
    output logic [5:0]       offset_loop_gain,
    output logic [4:0]       supply_voltage_code,
    output logic             nodata_timeout_en,
    output logic             sleep_active,
    output logic             ram_clear
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding shared by reset, clear, write and read paths

    function automatic logic is_stored(input logic [3:0] a);
        return (a >= hfc_pkg::REG_FIRST) && (a <= hfc_pkg::REG_LAST);
    endfunction : is_stored

    function automatic logic [11:0] reg_reset(input logic [3:0] a);
        logic [11:0] v;
        v = 12'h000;
        if (a == hfc_pkg::REG_CONFIG)
            v = hfc_pkg::RST_CONFIG;
        else if (a == hfc_pkg::REG_GATE_DRIVE_PARASITIC_CFG)
            v = hfc_pkg::RST_GATE_DRIVE_PARASITIC_CFG;
        else if (a == hfc_pkg::REG_SUPPLY)
            v = hfc_pkg::RST_SUPPLY;
        else if (a == hfc_pkg::REG_WAVSRC)
            v = hfc_pkg::RST_WAVSRC;
        else if (a == hfc_pkg::REG_SERIAL)
            v = hfc_pkg::RST_SERIAL;
        else if (a == hfc_pkg::REG_PRESS)
            v = hfc_pkg::RST_PRESS;
        else if (a == hfc_pkg::REG_CONV)
            v = hfc_pkg::RST_CONV;
        return v;
    endfunction : reg_reset

    ////////////////////////////////////////////////////////////////////////
    // Link domain: shifts words in and the broadcast word out

    logic [3:0]  bit_cnt_r;
    logic [14:0] rx_shift_r;
    logic [15:0] rx_word_r;
    logic        word_tgl_r;
    logic [15:0] tx_shift_r;
    logic [15:0] tx_hold_r;
    logic [11:0] regs_r [hfc_pkg::REG_FIRST:hfc_pkg::REG_LAST];

    // Frame signal resets the bit count; sclk may stop between frames
    always_ff @(posedge spi_sclk or posedge spi_cs_n or negedge reset_n)
    begin
        if (!reset_n || spi_cs_n)
        begin
            bit_cnt_r <= 4'h0;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge spi_sclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_shift_r <= 15'h0000;
            rx_word_r  <= 16'h0000;
            word_tgl_r <= 1'b0;
            tx_shift_r <= 16'h0000;
        end
        else
        begin
            rx_shift_r <= {rx_shift_r[13:0], spi_sdi};
            if (bit_cnt_r == 4'hf)
            begin
                rx_word_r  <= {rx_shift_r, spi_sdi};
                word_tgl_r <= ~word_tgl_r;
            end
            // tx_hold_r is frozen while chip select is seen low
            if (bit_cnt_r == 4'h0)
                tx_shift_r <= {tx_hold_r[14:0], 1'b0};
            else
                tx_shift_r <= {tx_shift_r[14:0], 1'b0};
        end
    end

    assign spi_sdo = !spi_cs_n
                   && regs_r[hfc_pkg::REG_SERIAL][hfc_pkg::SER_TE_BIT]
                   && ((bit_cnt_r == 4'h0) ? tx_hold_r[15] : tx_shift_r[15]);

    ////////////////////////////////////////////////////////////////////////
    // Crossings into the core domain

    logic [1:0] cs_sync_r;
    logic [1:0] tgl_sync_r;
    logic [1:0] hv_sync_r;
    logic [1:0] iov_sync_r;
    logic [1:0] sc_sync_r;
    logic       tgl_seen_r;
    logic       word_evt;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_sync_r  <= 2'h3;
            tgl_sync_r <= 2'h0;
            hv_sync_r  <= 2'h0;
            iov_sync_r <= 2'h0;
            sc_sync_r  <= 2'h0;
            tgl_seen_r <= 1'b0;
        end
        else
        begin
            cs_sync_r  <= {cs_sync_r[0], spi_cs_n};
            tgl_sync_r <= {tgl_sync_r[0], word_tgl_r};
            hv_sync_r  <= {hv_sync_r[0], high_voltage_sense_pin};
            iov_sync_r <= {iov_sync_r[0], input_current_sense_pin};
            sc_sync_r  <= {sc_sync_r[0], short_detect};
            tgl_seen_r <= tgl_sync_r[1];
        end
    end

    // rx_word_r holds for a whole word time, far longer than the sync delay
    assign word_evt = tgl_sync_r[1] ^ tgl_seen_r;

    ////////////////////////////////////////////////////////////////////////
    // Routing of received words

    logic        isel;
    logic        oe;
    logic        reg_wr;
    logic [3:0]  wr_addr;
    logic [11:0] wr_data;
    logic        cmd_pend_r;
    logic [15:0] cmd_word_r;
    logic        fifo_in_ready;

    assign isel    = regs_r[hfc_pkg::REG_WAVSRC][hfc_pkg::WAV_ISEL_BIT];
    assign oe      = regs_r[hfc_pkg::REG_CONFIG][hfc_pkg::CFG_OE_BIT];
    assign wr_addr = rx_word_r[15:12];
    assign wr_data = rx_word_r[11:0];
    assign reg_wr  = word_evt && !isel;

    // A word arriving while the FIFO is still full replaces the held one
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_pend_r <= 1'b0;
            cmd_word_r <= 16'h0000;
        end
        else if (word_evt && isel)
        begin
            cmd_pend_r <= 1'b1;
            cmd_word_r <= rx_word_r;
        end
        else if (fifo_in_ready)
        begin
            cmd_pend_r <= 1'b0;
        end
    end

    hfc_fifo #(
        .WIDTH (hfc_pkg::WORD_W),
        .DEPTH (hfc_pkg::CMD_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk       (core_clk),
        .reset_n   (reset_n),
        .in_data   (cmd_word_r),
        .in_valid  (cmd_pend_r),
        .in_ready  (fifo_in_ready),
        .out_data  (synth_cmd_data),
        .out_valid (synth_cmd_valid),
        .out_ready (synth_cmd_ready)
    );

    assign synth_cmd_space = fifo_in_ready && !cmd_pend_r;

    ////////////////////////////////////////////////////////////////////////
    // Select self-clear timer

    logic [7:0] idle_cnt_r;
    logic       isel_clr;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            idle_cnt_r <= 8'h00;
        end
        else if (word_evt)
        begin
            idle_cnt_r <= 8'h00;
        end
        else if (idle_cnt_r != 8'(hfc_pkg::ISEL_CLR_CYC))
        begin
            idle_cnt_r <= idle_cnt_r + 8'h01;
        end
    end

    assign isel_clr = (idle_cnt_r == 8'(hfc_pkg::ISEL_CLR_CYC))
                   && cs_sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // No-data timeout and power state

    hfc_pkg::hfc_pwr_t pwr_r;
    hfc_pkg::hfc_pwr_t pwr_nxt;
    logic [31:0]       nd_cnt_r;
    logic              nd_watch;
    logic              timeout_hit;
    logic              enter_sleep;
    logic              ram_clear_r;

    assign nd_watch = regs_r[hfc_pkg::REG_SUPPLY][hfc_pkg::SUP_NODATA_TIMEOUT_EN_BIT]
                   && (waveform_mode == hfc_pkg::MODE_DIRECT
                       || waveform_mode == hfc_pkg::MODE_FIFO)
                   && sample_needed
                   && (pwr_r != hfc_pkg::PWR_SLEEP);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nd_cnt_r <= 32'h0000_0000;
        end
        else if (!nd_watch || sample_strobe || enter_sleep)
        begin
            nd_cnt_r <= 32'h0000_0000;
        end
        else if (nd_cnt_r != 32'(TIMEOUT_CYC))
        begin
            nd_cnt_r <= nd_cnt_r + 32'h0000_0001;
        end
    end

    assign timeout_hit = nd_watch && !sample_strobe
                      && (nd_cnt_r == 32'(TIMEOUT_CYC));

    always_comb
    begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            hfc_pkg::PWR_IDLE:
                if (timeout_hit)
                    pwr_nxt = hfc_pkg::PWR_SLEEP;
                else if (oe)
                    pwr_nxt = hfc_pkg::PWR_ACTIVE;
                else if (regs_r[hfc_pkg::REG_CONFIG][hfc_pkg::CFG_DS_BIT])
                    pwr_nxt = hfc_pkg::PWR_SLEEP;
            hfc_pkg::PWR_ACTIVE:
                if (timeout_hit)
                    pwr_nxt = hfc_pkg::PWR_SLEEP;
                else if (!oe)
                    pwr_nxt = hfc_pkg::PWR_IDLE;
            hfc_pkg::PWR_SLEEP:
                if (reg_wr)
                    pwr_nxt = hfc_pkg::PWR_IDLE;
            default:
                pwr_nxt = hfc_pkg::PWR_IDLE;
        endcase
    end

    assign enter_sleep = (pwr_nxt == hfc_pkg::PWR_SLEEP)
                      && (pwr_r != hfc_pkg::PWR_SLEEP);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pwr_r       <= hfc_pkg::PWR_IDLE;
            ram_clear_r <= 1'b0;
        end
        else
        begin
            pwr_r       <= pwr_nxt;
            ram_clear_r <= enter_sleep;
        end
    end

    assign sleep_active = (pwr_r == hfc_pkg::PWR_SLEEP);
    assign ram_clear    = ram_clear_r;

    ////////////////////////////////////////////////////////////////////////
    // Register bank

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = hfc_pkg::REG_FIRST; i <= hfc_pkg::REG_LAST; i++)
                regs_r[i] <= reg_reset(4'(i));
        end
        else if (enter_sleep)
        begin
            for (int i = hfc_pkg::REG_FIRST; i <= hfc_pkg::REG_LAST; i++)
                regs_r[i] <= reg_reset(4'(i));
            if (timeout_hit)
                regs_r[hfc_pkg::REG_CONFIG][2:0] <= hfc_pkg::PLAY_TIMEOUT;
        end
        else
        begin
            if (isel_clr)
                regs_r[hfc_pkg::REG_WAVSRC][hfc_pkg::WAV_ISEL_BIT] <= 1'b0;
            if (reg_wr && is_stored(wr_addr))
            begin
                if (wr_addr == hfc_pkg::REG_WAVSRC)
                begin
                    // Reserved bits stay zero; mode frozen while playing
                    regs_r[wr_addr] <= {9'h000, wr_data[2],
                        oe ? regs_r[wr_addr][1:0] : wr_data[1:0]};
                end
                else
                begin
                    regs_r[wr_addr] <= wr_data;
                end
            end
        end
    end

    assign playback_rate       =
        regs_r[hfc_pkg::REG_CONFIG][hfc_pkg::CFG_PLAY_LSB +: 3];
    assign output_enable       = oe;
    assign waveform_mode       =
        regs_r[hfc_pkg::REG_WAVSRC][hfc_pkg::WAV_MODE_LSB +: 2];
    assign offset_loop_gain    =
        regs_r[hfc_pkg::REG_SUPPLY][hfc_pkg::SUP_GAIN_LSB +: 6];
    assign supply_voltage_code =
        regs_r[hfc_pkg::REG_SUPPLY][hfc_pkg::SUP_VIN_LSB +: 5];
    assign nodata_timeout_en   =
        regs_r[hfc_pkg::REG_SUPPLY][hfc_pkg::SUP_NODATA_TIMEOUT_EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Status word and broadcast readback

    logic [11:0] status_word;
    logic [4:0]  bcast_sel;
    logic [11:0] bcast_data;

    assign status_word = {controller_state,
                          hv_sync_r[1],
                          5'h00,
                          iov_sync_r[1],
                          sc_sync_r[1],
                          !fifo_in_ready,
                          sample_needed};

    assign bcast_sel = regs_r[hfc_pkg::REG_SERIAL][hfc_pkg::SER_BC_LSB +: 5];

    always_comb
    begin
        bcast_data = 12'h000;
        if (is_stored(bcast_sel[3:0]))
            bcast_data = regs_r[bcast_sel[3:0]];
        else if (bcast_sel[3:0] == hfc_pkg::REG_STATUS)
            bcast_data = status_word;
    end

    // Updated only between frames so the link side loads a steady word
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_hold_r <= 16'h0000;
        end
        else if (cs_sync_r[1])
        begin
            tx_hold_r <= bcast_sel[4] ? 16'h0000
                                      : {bcast_sel[3:0], bcast_data};
        end
    end

endmodule : hfc_frontend_regs

// [inc/hfc_pkg.sv]
// Constants, types and register layout of the haptic front-end registers
package hfc_pkg;

    localparam int unsigned CLK_HZ             = 10_000_000;
    localparam int unsigned CLK_MHZ            = CLK_HZ / 1_000_000;
    localparam int unsigned ISEL_CLR_NS        = 4000;
    localparam int unsigned ISEL_CLR_CYC       =
        (ISEL_CLR_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned NODATA_TIMEOUT_US  = 4000;
    localparam int unsigned NODATA_TIMEOUT_CYC = NODATA_TIMEOUT_US * CLK_MHZ;

    localparam int unsigned CMD_FIFO_DEPTH = 8;
    localparam int unsigned WORD_W         = 16;
    localparam int unsigned DATA_W         = 12;

    localparam logic [3:0] REG_FIRST  = 4'h5;
    localparam logic [3:0] REG_CONFIG = 4'h5;
    localparam logic [3:0] REG_GATE_DRIVE_PARASITIC_CFG = 4'h6;
    localparam logic [3:0] REG_SUPPLY = 4'h7;
    localparam logic [3:0] REG_WAVSRC = 4'h8;
    localparam logic [3:0] REG_SERIAL = 4'h9;
    localparam logic [3:0] REG_PRESS  = 4'ha;
    localparam logic [3:0] REG_CONV   = 4'hb;
    localparam logic [3:0] REG_LAST   = 4'hb;
    localparam logic [3:0] REG_STATUS = 4'hc;

    localparam logic [11:0] RST_CONFIG = 12'h000;
    localparam logic [11:0] RST_GATE_DRIVE_PARASITIC_CFG = 12'h00a;
    localparam logic [11:0] RST_SUPPLY = 12'h5cf;
    localparam logic [11:0] RST_WAVSRC = 12'h001;
    localparam logic [11:0] RST_SERIAL = 12'h7a8;
    localparam logic [11:0] RST_PRESS  = 12'h000;
    localparam logic [11:0] RST_CONV   = 12'h048;

    localparam int unsigned CFG_OE_BIT   = 4;
    localparam int unsigned CFG_DS_BIT   = 3;
    localparam int unsigned CFG_PLAY_LSB = 0;
    localparam logic [2:0]  PLAY_TIMEOUT = 3'h7;
    localparam int unsigned SUP_NODATA_TIMEOUT_EN_BIT = 11;
    localparam int unsigned SUP_VIN_LSB  = 6;
    localparam int unsigned SUP_GAIN_LSB = 0;
    localparam int unsigned WAV_ISEL_BIT = 2;
    localparam int unsigned WAV_MODE_LSB = 0;
    localparam int unsigned SER_BC_LSB   = 7;
    localparam int unsigned SER_TE_BIT   = 3;

    typedef enum logic [1:0] {
        MODE_DIRECT,
        MODE_FIFO,
        MODE_RAM_PLAY,
        MODE_RAM_SYNTH
    } hfc_mode_t;

    typedef enum logic [1:0] {
        PWR_IDLE,
        PWR_ACTIVE,
        PWR_SLEEP
    } hfc_pwr_t;

endpackage : hfc_pkg

// [verification/hfc_frontend_regs_monitor.sv]
// Port-level assertions for the front-end register block
`timescale 1ns/10ps
module hfc_frontend_regs_monitor #(
    parameter int unsigned TIMEOUT_CYC = 50
) (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        spi_cs_n,
    input wire logic        spi_sdo,
    input wire logic        sample_needed,
    input wire logic        sample_strobe,
    input wire logic [15:0] synth_cmd_data,
    input wire logic        synth_cmd_valid,
    input wire logic        synth_cmd_ready,
    input wire logic [2:0]  playback_rate,
    input wire logic [1:0]  waveform_mode,
    input wire logic        output_enable,
    input wire logic [5:0]  offset_loop_gain,
    input wire logic [4:0]  supply_voltage_code,
    input wire logic        nodata_timeout_en,
    input wire logic        sleep_active,
    input wire logic        ram_clear
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    //////////////////////////////////////////////////////////////
    int unsigned starve_r;
    // Slack of three cycles allows for the registered sleep entry
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            starve_r <= 0;
        else if (nodata_timeout_en && !waveform_mode[1] && sample_needed &&
                 !sample_strobe && !sleep_active)
            starve_r <= starve_r + 1;
        else
            starve_r <= 0;
    end
    sequence sleep_entry;
        $rose(sleep_active);
    endsequence
    sequence clear_pulse;
        ram_clear ##1 !ram_clear;
    endsequence
    sdo_deselect_a: assert property (spi_cs_n |-> !spi_sdo)
        else $error("sdo high while deselected");
    sleep_clear_a: assert property (sleep_entry |-> clear_pulse)
        else $error("no memory clear after sleep");
    clear_cause_a: assert property (
        ram_clear |-> sleep_active && !$past(sleep_active))
        else $error("memory clear without sleep");
    sleep_regs_a: assert property (
        sleep_entry |-> !output_enable && waveform_mode == 2'h1 &&
        offset_loop_gain == 6'h0f && supply_voltage_code == 5'h17 &&
        !nodata_timeout_en)
        else $error("registers kept over sleep");
    sleep_rate_a: assert property (
        sleep_entry |-> playback_rate == 3'h7 || playback_rate == 3'h0)
        else $error("bad rate code on sleep");
    starve_bound_a: assert property (
        starve_r <= TIMEOUT_CYC + 3)
        else $error("no sleep after starvation");
    mode_lock_a: assert property (
        output_enable && $past(output_enable) |-> $stable(waveform_mode))
        else $error("mode changed while enabled");
    cmd_hold_a: assert property (
        synth_cmd_valid && !synth_cmd_ready && !sleep_active |=>
        sleep_active || synth_cmd_valid && $stable(synth_cmd_data))
        else $error("command lost while stalled");
endmodule : hfc_frontend_regs_monitor
bind hfc_frontend_regs hfc_frontend_regs_monitor #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
) hfc_frontend_regs_monitor_inst (
    .core_clk, .reset_n, .spi_cs_n, .spi_sdo, .sample_needed,
    .sample_strobe, .synth_cmd_data, .synth_cmd_valid, .synth_cmd_ready,
    .playback_rate, .waveform_mode, .output_enable, .offset_loop_gain,
    .supply_voltage_code, .nodata_timeout_en, .sleep_active, .ram_clear
);

// [verification/hfc_spi_host.sv]
// Behavioural serial host driving frames into the register port
`timescale 1ns/10ps
module hfc_spi_host (
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
    end
    //////////////////////////////////////////////////////////////
    // Setup after select covers the 300 ns sync need
    task automatic open_frame();
        #7;
        spi_cs_n = 1'b0;
        #330;
    endtask : open_frame
    // Clock stands still outside frames; 30 ns period inside
    task automatic shift_word(input logic [15:0] tx, output logic [15:0] rx);
        for (int i = 15; i >= 0; i--)
        begin
            spi_sdi = tx[i];
            #15;
            rx[i] = spi_sdo;
            spi_sclk = 1'b1;
            #15;
            spi_sclk = 1'b0;
        end
        #30;
    endtask : shift_word
    task automatic close_frame();
        #20;
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
        #500;
    endtask : close_frame
endmodule : hfc_spi_host

// [verification/test_haptic_frontend_config_status.sv]
// Self-checking bench for the haptic front-end register block
`timescale 1ns/10ps
module test_haptic_frontend_config_status;
    localparam int unsigned NODATA_TIMEOUT_EN = 50;
    logic core_clk = 1'b0;
    logic reset_n, spi_sclk, spi_cs_n, spi_sdi, spi_sdo;
    logic sample_needed, sample_strobe, high_voltage_sense_pin;
    logic input_current_sense_pin, short_detect, synth_cmd_ready;
    logic synth_cmd_valid, synth_cmd_space, output_enable;
    logic nodata_timeout_en, sleep_active, ram_clear;
    logic [1:0]  controller_state, waveform_mode;
    logic [2:0]  playback_rate;
    logic [4:0]  supply_voltage_code;
    logic [5:0]  offset_loop_gain;
    logic [15:0] synth_cmd_data, rx, ex, cnt;
    int          n_fail = 0;
    int          comparisons = 0;
    logic [11:0] rst_tab [5:11] = '{hfc_pkg::RST_CONFIG, hfc_pkg::RST_GATE_DRIVE_PARASITIC_CFG,
        hfc_pkg::RST_SUPPLY, hfc_pkg::RST_WAVSRC, hfc_pkg::RST_SERIAL,
        hfc_pkg::RST_PRESS, hfc_pkg::RST_CONV};
    wire logic [10:0] mode_v = {3'h0, sleep_active, nodata_timeout_en,
        output_enable, waveform_mode, playback_rate};
    wire logic [10:0] gain_v = {supply_voltage_code, offset_loop_gain};
    hfc_spi_host hfc_spi_host_inst (.spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo);
    hfc_frontend_regs #(.TIMEOUT_CYC(NODATA_TIMEOUT_EN)) hfc_frontend_regs_inst (
        .core_clk, .reset_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
        .sample_needed, .sample_strobe, .controller_state,
        .high_voltage_sense_pin, .input_current_sense_pin, .short_detect,
        .synth_cmd_data, .synth_cmd_valid, .synth_cmd_ready, .synth_cmd_space,
        .playback_rate, .waveform_mode, .output_enable, .offset_loop_gain,
        .supply_voltage_code, .nodata_timeout_en, .sleep_active, .ram_clear);
    always #50 core_clk = ~core_clk;
    //////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_port(input logic [10:0] got, input logic [10:0] exp);
        chk_word({5'h00, got}, {5'h00, exp});
    endtask : chk_port
    task automatic frame(input logic [15:0] tx, output logic [15:0] r);
        hfc_spi_host_inst.open_frame();
        hfc_spi_host_inst.shift_word(tx, r);
        hfc_spi_host_inst.close_frame();
        @(negedge core_clk);
    endtask : frame
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        logic [15:0] r;
        frame({a, d}, r);
    endtask : wr
    // Reads go through a select write, so they cost two frames
    task automatic rd(input logic [4:0] bc);
        wr(4'h9, {bc, 7'h28});
        frame(16'h0000, rx);
    endtask : rd
    task automatic print_verdict();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    //////////////////////////////////////////////////////////////
    initial
    begin
        #5_000_000;
        n_fail++;
        print_verdict();
    end
    initial
    begin
        reset_n = 1'b0;
        sample_needed = 1'b0;
        sample_strobe = 1'b0;
        controller_state = 2'h0;
        high_voltage_sense_pin = 1'b0;
        input_current_sense_pin = 1'b0;
        short_detect = 1'b0;
        synth_cmd_ready = 1'b0;
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_port(mode_v, 11'h008);
        chk_port(gain_v, hfc_pkg::RST_SUPPLY[10:0]);
        frame(16'h0000, rx);
        chk_word(rx, 16'hf000);
        for (int a = 5; a < 12; a++)
        begin
            rd(a[4:0]);
            ex = {a[3:0], (a == 9) ? 12'h4a8 : rst_tab[a]};
            chk_word(rx, ex);
        end
        wr(4'h0, 12'hfff);
        wr(4'hc, 12'hfff);
        rd(5'h00);
        chk_word(rx, 16'h0000);
        rd(5'h10);
        chk_word(rx, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            controller_state = i[1:0];
            high_voltage_sense_pin = i[0];
            input_current_sense_pin = i[1];
            short_detect = !i[0];
            rd(5'h0c);
            ex = {4'hc, i[1:0], i[0], 5'h00, i[1], !i[0], 2'h0};
            chk_word(rx, ex);
        end
        for (int c = 0; c < 7; c++)
        begin
            wr(4'h5, {9'h000, c[2:0]});
            chk_port(mode_v, {8'h01, c[2:0]});
        end
        wr(4'h5, 12'h010);
        wr(4'h8, 12'h003);
        chk_port(mode_v, 11'h028);
        wr(4'h5, 12'h000);
        wr(4'h8, 12'h003);
        chk_port(mode_v, 11'h018);
        wr(4'h7, 12'h47f);
        chk_port(gain_v, 11'h47f);
        wr(4'h7, 12'h7c0);
        chk_port(gain_v, 11'h7c0);
        wr(4'h9, 12'h2a0);
        frame(16'h0000, rx);
        chk_word(rx, 16'h0000);
        rd(5'h07);
        chk_word(rx, 16'h77c0);
        wr(4'h8, 12'h004);
        hfc_spi_host_inst.open_frame();
        for (int i = 0; i < 9; i++)
        begin
            if (i == 8)
                repeat (60) @(negedge core_clk);
            hfc_spi_host_inst.shift_word(16'ha100 + i[15:0], rx);
        end
        hfc_spi_host_inst.close_frame();
        chk_port({10'h0, synth_cmd_space}, 11'h000);
        repeat (60) @(negedge core_clk);
        wr(4'h5, 12'h002);
        chk_port(mode_v, 11'h002);
        rd(5'h0a);
        chk_word(rx, 16'ha000);
        cnt = 16'h0;
        // Consumer stalls every other cycle while draining
        for (int k = 0; k < 60 && cnt < 9; k++)
        begin
            @(negedge core_clk);
            synth_cmd_ready = 1'b0;
            if (synth_cmd_valid === 1'b1 && k[0])
            begin
                chk_word(synth_cmd_data, 16'ha100 + cnt);
                synth_cmd_ready = 1'b1;
                cnt++;
            end
        end
        @(negedge core_clk);
        synth_cmd_ready = 1'b0;
        chk_word(cnt, 16'h0009);
        wr(4'h7, 12'hdcf);
        sample_needed = 1'b1;
        repeat (NODATA_TIMEOUT_EN - 10) @(negedge core_clk);
        sample_strobe = 1'b1;
        @(negedge core_clk);
        sample_strobe = 1'b0;
        repeat (NODATA_TIMEOUT_EN - 10) @(negedge core_clk);
        chk_port({10'h0, sleep_active}, 11'h000);
        for (int k = 0; k < 40 && sleep_active !== 1'b1; k++)
            @(negedge core_clk);
        if (sleep_active !== 1'b1)
        begin
            n_fail++;
            print_verdict();
        end
        chk_port(mode_v, 11'h08f);
        chk_port(gain_v, hfc_pkg::RST_SUPPLY[10:0]);
        chk_port({10'h0, ram_clear}, 11'h001);
        @(negedge core_clk);
        chk_port({10'h0, ram_clear}, 11'h000);
        sample_needed = 1'b0;
        wr(4'h5, 12'h005);
        chk_port(mode_v, 11'h00d);
        wr(4'h5, 12'h008);
        chk_port(mode_v, 11'h088);
        wr(4'h5, 12'h000);
        chk_port(mode_v, 11'h008);
        print_verdict();
    end
endmodule : test_haptic_frontend_config_status
